// ### design/eipl_pkg.sv
// Shared constants and types of the external interrupt pin logic
package eipl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_ISTS = 12'h004;
    localparam logic [11:0] ADDR_IMSK = 12'h008;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions of irq_pin_status_control
    localparam int POS_PULL_DEVICE_DISABLE      = 6;
    localparam int POS_POLARITY_SELECT          = 5;
    localparam int POS_PIN_FUNCTION_ENABLE      = 4;
    localparam int POS_REQUEST_EVENT_FLAG       = 3;
    localparam int POS_EVENT_ACKNOWLEDGE        = 2;
    localparam int POS_REQUEST_INTERRUPT_ENABLE = 1;
    localparam int POS_EDGE_LEVEL_MODE          = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions of the event status and mask registers
    localparam int POS_STS_EVENT       = 0;
    localparam int POS_STS_ACK_REFUSED = 1;
    localparam int STS_WIDTH           = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [7:0]           RST_CTRL = 8'h00;
    localparam logic [STS_WIDTH-1:0] RST_ISTS = 2'h0;
    localparam logic [STS_WIDTH-1:0] RST_IMSK = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer sequencing
    typedef enum logic [0:0] {
        APB_IDLE = 1'b0,
        APB_RESP = 1'b1
    } eipl_apb_state_type;

endpackage

// ### design/eipl_sync.sv
// Two-stage synchroniser for the external request pin
`timescale 1ns/1ps
module eipl_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_async,
    output logic      pin_sync
);

    typedef struct packed {
        logic stage1;
        logic stage2;
    } eipl_sync_state_type;

    eipl_sync_state_type st_r;
    eipl_sync_state_type st_nxt;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.stage1 = pin_async;
        st_nxt.stage2 = st_r.stage1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_sync = st_r.stage2;

endmodule

// ### design/eipl_detect.sv
// Polarity, edge and level qualifier for the synchronised pin
`timescale 1ns/1ps
module eipl_detect (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_sync,
    input  wire logic polarity,
    input  wire logic enable,
    output logic      level_hit,
    output logic      edge_hit
);

    typedef struct packed {
        logic prev_pin;
    } eipl_detect_state_type;

    eipl_detect_state_type st_r;
    eipl_detect_state_type st_nxt;
    logic                  now_asserted;
    logic                  was_asserted;

    always_comb begin
        st_nxt          = st_r;
        st_nxt.prev_pin = pin_sync;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Asserted level follows the polarity choice
    assign now_asserted = polarity ? pin_sync : ~pin_sync;
    assign was_asserted = polarity ? st_r.prev_pin : ~st_r.prev_pin;
    assign level_hit    = enable & now_asserted;
    assign edge_hit     = enable & now_asserted & ~was_asserted;

endmodule

// ### design/eipl_top.sv
// External interrupt request pin logic with APB register access
// Notes on behaviour
// - Bit 6 set turns the pull device off while the pin function is on, clear leaves it on.
// - Bit 5 picks falling/low sensitivity when 0 and rising/high sensitivity when 1.
// - With the pin function on and rising polarity, the pull-up becomes a pull-down.
// - Bit 4 turns the pin's interrupt request function on when set and off when clear.
// - Bit 3 is a read-only flag that reads 1 once a qualifying event is seen and 0 otherwise.
// - Writing 1 to bit 2 clears the flag, writing 0 does nothing, and bit 2 always reads 0.
// - In edge-and-level mode an acknowledge cannot clear the flag while the pin stays asserted.
// - Bit 1 set makes a core request whenever the flag is 1, clear leaves software to poll.
// - Bit 0 picks edge-only detection when 0 and edge-and-level detection when 1.
// - A deasserted to asserted transition sets the flag, and level mode keeps it set while asserted.
`timescale 1ns/1ps
module eipl_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        irq_pin_in,
    output logic             pull_up_en,
    output logic             pull_down_en,
    output logic             core_irq_req,
    output logic             event_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        eipl_pkg::eipl_apb_state_type               apb;
        logic                                       pready;
        logic                                       pslverr;
        logic [31:0]                                prdata;
        logic                                       pull_device_disable;
        logic                                       polarity_select;
        logic                                       pin_function_enable;
        logic                                       request_event_flag;
        logic                                       request_interrupt_enable;
        logic                                       edge_level_mode;
        logic [eipl_pkg::STS_WIDTH-1:0]             sts;
        logic [eipl_pkg::STS_WIDTH-1:0]             msk;
        logic                                       core_req;
        logic                                       event_irq;
        logic                                       pull_up;
        logic                                       pull_down;
    } eipl_state_type;

    eipl_state_type st_r;
    eipl_state_type st_nxt;

    logic pin_sync;
    logic level_hit;
    logic edge_hit;
    logic access_phase;
    logic write_done;
    logic ack_hit;
    logic level_hold;
    logic event_set;
    logic ack_refused;
    logic addr_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Pin front end

    eipl_sync u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (irq_pin_in),
        .pin_sync  (pin_sync)
    );

    eipl_detect u_detect (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_sync  (pin_sync),
        .polarity  (st_r.polarity_select),
        .enable    (st_r.pin_function_enable),
        .level_hit (level_hit),
        .edge_hit  (edge_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == eipl_pkg::ADDR_CTRL) || (a == eipl_pkg::ADDR_ISTS) || (a == eipl_pkg::ADDR_IMSK);
    endfunction

    function automatic logic [7:0] ctrl_image(input eipl_state_type s);
        logic [7:0] v;
        v                                             = 8'h00;
        v[eipl_pkg::POS_PULL_DEVICE_DISABLE]          = s.pull_device_disable;
        v[eipl_pkg::POS_POLARITY_SELECT]              = s.polarity_select;
        v[eipl_pkg::POS_PIN_FUNCTION_ENABLE]          = s.pin_function_enable;
        v[eipl_pkg::POS_REQUEST_EVENT_FLAG]           = s.request_event_flag;
        v[eipl_pkg::POS_EVENT_ACKNOWLEDGE]            = 1'b0;
        v[eipl_pkg::POS_REQUEST_INTERRUPT_ENABLE]     = s.request_interrupt_enable;
        v[eipl_pkg::POS_EDGE_LEVEL_MODE]              = s.edge_level_mode;
        ctrl_image                                    = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    assign addr_ok      = addr_mapped(paddr);
    assign access_phase = psel & penable;
    // Writes land only on the completing edge
    assign write_done   = access_phase & st_r.pready & pwrite & addr_ok;
    assign ack_hit      = write_done && (paddr == eipl_pkg::ADDR_CTRL) && pwdata[eipl_pkg::POS_EVENT_ACKNOWLEDGE];
    // level mode holds the flag while asserted
    assign level_hold   = st_r.edge_level_mode & level_hit;
    // mode picks edge only or edge and level
    assign event_set    = edge_hit | level_hold;
    assign ack_refused  = ack_hit & level_hold;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;

        // Bus answer: one wait cycle, then pready for one cycle
        case (st_r.apb)
            eipl_pkg::APB_IDLE: begin
                st_nxt.pready  = 1'b0;
                st_nxt.pslverr = 1'b0;
                if (access_phase) begin
                    st_nxt.apb     = eipl_pkg::APB_RESP;
                    st_nxt.pready  = 1'b1;
                    st_nxt.pslverr = ~addr_ok;
                    st_nxt.prdata  = 32'h0000_0000;
                    if (!pwrite) begin
                        case (paddr)
                            eipl_pkg::ADDR_CTRL: st_nxt.prdata[7:0] = ctrl_image(st_r);
                            eipl_pkg::ADDR_ISTS: st_nxt.prdata[eipl_pkg::STS_WIDTH-1:0] = st_r.sts;
                            eipl_pkg::ADDR_IMSK: st_nxt.prdata[eipl_pkg::STS_WIDTH-1:0] = st_r.msk;
                            default:             st_nxt.prdata = 32'h0000_0000;
                        endcase
                    end
                end
            end
            eipl_pkg::APB_RESP: begin
                st_nxt.apb     = eipl_pkg::APB_IDLE;
                st_nxt.pready  = 1'b0;
                st_nxt.pslverr = 1'b0;
            end
            default: begin
                st_nxt.apb     = eipl_pkg::APB_IDLE;
                st_nxt.pready  = 1'b0;
                st_nxt.pslverr = 1'b0;
            end
        endcase

        // Control fields
        if (write_done && (paddr == eipl_pkg::ADDR_CTRL)) begin
            st_nxt.pull_device_disable      = pwdata[eipl_pkg::POS_PULL_DEVICE_DISABLE];
            st_nxt.polarity_select          = pwdata[eipl_pkg::POS_POLARITY_SELECT];
            st_nxt.pin_function_enable      = pwdata[eipl_pkg::POS_PIN_FUNCTION_ENABLE];
            st_nxt.request_interrupt_enable = pwdata[eipl_pkg::POS_REQUEST_INTERRUPT_ENABLE];
            st_nxt.edge_level_mode          = pwdata[eipl_pkg::POS_EDGE_LEVEL_MODE];
        end
        if (write_done && (paddr == eipl_pkg::ADDR_IMSK)) begin
            st_nxt.msk = pwdata[eipl_pkg::STS_WIDTH-1:0];
        end

        // event flag, set wins over acknowledge
        if (ack_hit) begin
            st_nxt.request_event_flag = 1'b0;
        end
        if (event_set) begin
            st_nxt.request_event_flag = 1'b1;
        end

        // Sticky status, write one to clear, set wins
        if (write_done && (paddr == eipl_pkg::ADDR_ISTS)) begin
            st_nxt.sts = st_r.sts & ~pwdata[eipl_pkg::STS_WIDTH-1:0];
        end
        if (edge_hit) begin
            st_nxt.sts[eipl_pkg::POS_STS_EVENT] = 1'b1;
        end
        if (ack_refused) begin
            st_nxt.sts[eipl_pkg::POS_STS_ACK_REFUSED] = 1'b1;
        end

        // core request follows flag and enable
        st_nxt.core_req  = st_nxt.request_event_flag & st_nxt.request_interrupt_enable;
        st_nxt.event_irq = |(st_nxt.sts & st_nxt.msk);

        // rising polarity swaps pull-up for pull-down
        st_nxt.pull_up   = st_nxt.pin_function_enable & ~st_nxt.pull_device_disable & ~st_nxt.polarity_select;
        st_nxt.pull_down = st_nxt.pin_function_enable & ~st_nxt.pull_device_disable & st_nxt.polarity_select;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r                          <= '0;
            st_r.apb                      <= eipl_pkg::APB_IDLE;
            st_r.pull_device_disable      <= eipl_pkg::RST_CTRL[eipl_pkg::POS_PULL_DEVICE_DISABLE];
            st_r.polarity_select          <= eipl_pkg::RST_CTRL[eipl_pkg::POS_POLARITY_SELECT];
            st_r.pin_function_enable      <= eipl_pkg::RST_CTRL[eipl_pkg::POS_PIN_FUNCTION_ENABLE];
            st_r.request_event_flag       <= eipl_pkg::RST_CTRL[eipl_pkg::POS_REQUEST_EVENT_FLAG];
            st_r.request_interrupt_enable <= eipl_pkg::RST_CTRL[eipl_pkg::POS_REQUEST_INTERRUPT_ENABLE];
            st_r.edge_level_mode          <= eipl_pkg::RST_CTRL[eipl_pkg::POS_EDGE_LEVEL_MODE];
            st_r.sts                      <= eipl_pkg::RST_ISTS;
            st_r.msk                      <= eipl_pkg::RST_IMSK;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata       = st_r.prdata;
    assign pready       = st_r.pready;
    assign pslverr      = st_r.pslverr;
    assign pull_up_en   = st_r.pull_up;
    assign pull_down_en = st_r.pull_down;
    assign core_irq_req = st_r.core_req;
    assign event_irq    = st_r.event_irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_wait_then_ready;
        !pready ##1 pready;
    endsequence

    sequence s_ack_no_hold;
        ack_hit && !level_hold && !event_set;
    endsequence

    a_bus_answer_timing: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_setup |=> s_wait_then_ready)
        else $error("bus answer not after one wait cycle");

    a_ack_reads_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && psel && paddr == eipl_pkg::ADDR_CTRL) |-> !prdata[eipl_pkg::POS_EVENT_ACKNOWLEDGE])
        else $error("acknowledge bit read back as one");

    a_ack_clears_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_ack_no_hold |=> !st_r.request_event_flag)
        else $error("acknowledge did not clear flag");

    a_level_blocks_ack: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ack_hit && st_r.edge_level_mode && level_hit) |=> st_r.request_event_flag && st_r.sts[1])
        else $error("acknowledge cleared flag while level held");

    a_edge_sets_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        edge_hit |=> st_r.request_event_flag && (st_r.core_req == st_r.request_interrupt_enable))
        else $error("edge did not set flag");

    a_no_event_disabled: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!st_r.pin_function_enable && !st_r.request_event_flag) |=> !st_r.request_event_flag)
        else $error("event while pin function off");

    a_core_req_follows: assert property (
        @(posedge pclk) disable iff (!presetn)
        core_irq_req == (st_r.request_event_flag && st_r.request_interrupt_enable))
        else $error("core request does not match flag and enable");

    a_pull_select: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pull_down_en == (st_r.pin_function_enable && !st_r.pull_device_disable && st_r.polarity_select))
        && !(pull_up_en && pull_down_en))
        else $error("pull device selection wrong");

    a_pull_disable: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r.pull_device_disable |-> !pull_up_en && !pull_down_en)
        else $error("pull device on while disabled");

    a_flag_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.request_event_flag && !ack_hit) |=> st_r.request_event_flag)
        else $error("flag dropped without acknowledge");

    a_mode_edge_only: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!st_r.edge_level_mode && !edge_hit && ack_hit) |=> !st_r.request_event_flag)
        else $error("edge mode flag held after acknowledge");

    a_polarity_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        level_hit |-> (pin_sync == st_r.polarity_select))
        else $error("asserted level does not follow polarity");

    a_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        event_irq == |(st_r.sts & st_r.msk))
        else $error("interrupt output does not match status and mask");

    a_pin_off_pulls: assert property (
        @(posedge pclk) disable iff (!presetn)
        !st_r.pin_function_enable |-> !pull_up_en && !pull_down_en)
        else $error("pull device on while pin function off");

    a_level_keeps_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.edge_level_mode && level_hit) |=> st_r.request_event_flag)
        else $error("flag not held while level asserted");

    a_ack_zero_ignored: assert property (
        @(posedge pclk) disable iff (!presetn)
        (write_done && paddr == eipl_pkg::ADDR_CTRL && !pwdata[eipl_pkg::POS_EVENT_ACKNOWLEDGE]
            && st_r.request_event_flag) |=> st_r.request_event_flag)
        else $error("written zero acknowledge cleared flag");

    a_edge_sets_status: assert property (
        @(posedge pclk) disable iff (!presetn)
        edge_hit |=> st_r.sts[eipl_pkg::POS_STS_EVENT])
        else $error("edge did not set event status");

    a_unmapped_error: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_phase && !st_r.pready && !addr_ok) |=> pready && pslverr)
        else $error("unmapped access not answered with error");

endmodule

// ### sim/eipl_pin_src.sv
// External request source model driving the interrupt pin
`timescale 1ns/1ps
module eipl_pin_src (
    input  wire logic pclk,
    input  wire logic drive_en,
    input  wire logic drive_val,
    input  wire logic pull_up_en,
    input  wire logic pull_down_en,
    output logic      irq_pin
);
    logic last_r = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Driven level wins, then the pull, else a wandering line
    always_comb begin
        if (drive_en) begin
            irq_pin = drive_val;
        end else if (pull_up_en) begin
            irq_pin = 1'b1;
        end else if (pull_down_en) begin
            irq_pin = 1'b0;
        end else begin
            irq_pin = ~last_r;
        end
    end

    always @(posedge pclk) begin
        last_r <= irq_pin;
    end
endmodule

// ### sim/external_irq_pin_logic_bench.sv
// Self-checking bench of the external interrupt pin logic
`timescale 1ns/1ps
module external_irq_pin_logic_bench;
    localparam logic [31:0] PDD = 32'h1 << eipl_pkg::POS_PULL_DEVICE_DISABLE;
    localparam logic [31:0] POL = 32'h1 << eipl_pkg::POS_POLARITY_SELECT;
    localparam logic [31:0] PE  = 32'h1 << eipl_pkg::POS_PIN_FUNCTION_ENABLE;
    localparam logic [31:0] FLG = 32'h1 << eipl_pkg::POS_REQUEST_EVENT_FLAG;
    localparam logic [31:0] ACK = 32'h1 << eipl_pkg::POS_EVENT_ACKNOWLEDGE;
    localparam logic [31:0] IE  = 32'h1 << eipl_pkg::POS_REQUEST_INTERRUPT_ENABLE;
    localparam logic [31:0] MD  = 32'h1 << eipl_pkg::POS_EDGE_LEVEL_MODE;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_pin;
    logic        pull_up_en;
    logic        pull_down_en;
    logic        core_irq_req;
    logic        event_irq;
    logic        drv_en;
    logic        drv_val;
    logic [31:0] rd;
    logic        err;
    logic [31:0] v;
    int          fail_count;
    int          n_tests;
    int          k;

    eipl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_pin_in(irq_pin), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
        .core_irq_req(core_irq_req), .event_irq(event_irq));

    eipl_pin_src src_u (.pclk(pclk), .drive_en(drv_en), .drive_val(drv_val), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .irq_pin(irq_pin));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task finish_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            finish_test();
        end else begin
            rd      = prdata;
            err     = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
        check({31'h0, err}, {31'h0, exp_err});
    endtask

    // Outputs {up, down, core, event} under a mask
    task sig_chk(input logic [3:0] e, input logic [3:0] m);
        repeat (2) @(negedge pclk);
        check({28'h0, {pull_up_en, pull_down_en, core_irq_req, event_irq} & m}, {28'h0, e & m});
    endtask

    task pin(input logic lvl);
        @(posedge pclk);
        drv_en  <= 1'b1;
        drv_val <= lvl;
        repeat (4) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        fail_count = 0;
        n_tests = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        drv_en = 1'b0;
        drv_val = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(eipl_pkg::ADDR_CTRL, 32'h0, 1'b0);
        rd_chk(eipl_pkg::ADDR_ISTS, 32'h0, 1'b0);
        rd_chk(eipl_pkg::ADDR_IMSK, 32'h0, 1'b0);
        sig_chk(4'h0, 4'hf);
        rd_chk(12'h00c, 32'h0, 1'b1);
        wr(12'h010, 32'hff);
        check({31'h0, err}, 32'h1);
        // Pull selection over all pin function, polarity and disable settings, pin driven high
        rd_chk(eipl_pkg::ADDR_CTRL, 32'h0, 1'b0);
        pin(1'b1);
        for (k = 0; k < 8; k++) begin
            v = (k[0] ? PE : 32'h0) | (k[1] ? POL : 32'h0) | (k[2] ? PDD : 32'h0);
            wr(eipl_pkg::ADDR_CTRL, v);
            sig_chk({k[0] & ~k[2] & ~k[1], k[0] & ~k[2] & k[1], 2'b00}, 4'hc);
            xfer(1'b0, eipl_pkg::ADDR_CTRL, 32'h0);
            check(rd & ~FLG, v);
        end
        // Falling edge, edge-only mode
        wr(eipl_pkg::ADDR_CTRL, PE | IE | ACK);
        wr(eipl_pkg::ADDR_ISTS, 32'h3);
        rd_chk(eipl_pkg::ADDR_CTRL, PE | IE, 1'b0);
        pin(1'b0);
        rd_chk(eipl_pkg::ADDR_CTRL, PE | IE | FLG, 1'b0);
        sig_chk(4'h2, 4'h3);
        rd_chk(eipl_pkg::ADDR_ISTS, 32'h1, 1'b0);
        wr(eipl_pkg::ADDR_IMSK, 32'h1);
        sig_chk(4'h3, 4'h3);
        wr(eipl_pkg::ADDR_ISTS, 32'h1);
        sig_chk(4'h2, 4'h3);
        rd_chk(eipl_pkg::ADDR_ISTS, 32'h0, 1'b0);
        wr(eipl_pkg::ADDR_CTRL, PE | IE);
        rd_chk(eipl_pkg::ADDR_CTRL, PE | IE | FLG, 1'b0);
        wr(eipl_pkg::ADDR_CTRL, PE);
        sig_chk(4'h0, 4'h2);
        wr(eipl_pkg::ADDR_CTRL, PE | IE | ACK);
        rd_chk(eipl_pkg::ADDR_CTRL, PE | IE, 1'b0);
        sig_chk(4'h0, 4'h2);
        // Held low level, edge-and-level mode
        wr(eipl_pkg::ADDR_CTRL, PE | IE | MD);
        rd_chk(eipl_pkg::ADDR_CTRL, PE | IE | MD | FLG, 1'b0);
        wr(eipl_pkg::ADDR_CTRL, PE | IE | MD | ACK);
        rd_chk(eipl_pkg::ADDR_CTRL, PE | IE | MD | FLG, 1'b0);
        rd_chk(eipl_pkg::ADDR_ISTS, 32'h2, 1'b0);
        wr(eipl_pkg::ADDR_IMSK, 32'h2);
        sig_chk(4'h3, 4'h3);
        pin(1'b1);
        rd_chk(eipl_pkg::ADDR_CTRL, PE | IE | MD | FLG, 1'b0);
        wr(eipl_pkg::ADDR_CTRL, PE | IE | MD | ACK);
        rd_chk(eipl_pkg::ADDR_CTRL, PE | IE | MD, 1'b0);
        // Rising polarity
        wr(eipl_pkg::ADDR_ISTS, 32'h3);
        wr(eipl_pkg::ADDR_CTRL, PE | POL | IE | ACK);
        pin(1'b0);
        rd_chk(eipl_pkg::ADDR_CTRL, PE | POL | IE, 1'b0);
        sig_chk(4'h4, 4'hc);
        pin(1'b1);
        rd_chk(eipl_pkg::ADDR_CTRL, PE | POL | IE | FLG, 1'b0);
        rd_chk(eipl_pkg::ADDR_ISTS, 32'h1, 1'b0);
        wr(eipl_pkg::ADDR_CTRL, PE | POL | IE | ACK);
        pin(1'b0);
        rd_chk(eipl_pkg::ADDR_CTRL, PE | POL | IE, 1'b0);
        // Function off: no events from pin activity
        wr(eipl_pkg::ADDR_CTRL, ACK);
        pin(1'b1);
        pin(1'b0);
        pin(1'b1);
        rd_chk(eipl_pkg::ADDR_CTRL, 32'h0, 1'b0);
        sig_chk(4'h0, 4'he);
        finish_test();
    end
endmodule
